// ===== core/tcsm_pkg.sv
// constants and types for the timer 0/1 clock select and counter block
// assumes one system clock domain and a byte-wide register port
package tcsm_pkg;

    // ----------------------------------------------------------------
    // register offsets on the byte port
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h8E;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hA8;
    localparam logic [7:0] ADDR_EXT_CFG = 8'hE4;

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] CLK_SEL_RESET = 8'h00;
    localparam logic [7:0] CLK_SEL_WMASK = 8'h7B;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RF_TF1_BIT = 7;
    localparam int RF_TR1_BIT = 6;
    localparam int RF_TF0_BIT = 5;
    localparam int RF_TR0_BIT = 4;
    localparam int IRQ_ET0_BIT = 1;
    localparam int IRQ_ET1_BIT = 3;
    localparam int EXT_GATE_ZERO_POLARITY_BIT = 3;
    localparam int EXT_GATE_ONE_POLARITY_BIT = 7;

    // synchroniser lanes
    localparam int SYNC_LANES = 5;
    localparam int SYNC_EXTCLK = 0;
    localparam int SYNC_EVT0 = 1;
    localparam int SYNC_TIMER_ZERO_GATE_EN = 3;

    // ----------------------------------------------------------------
    // prescaler division ratios
    // ----------------------------------------------------------------
    localparam int DIV_SYS12 = 12;
    localparam int DIV_SYS4 = 4;
    localparam int DIV_SYS48 = 48;
    localparam int DIV_EXT8 = 8;
    localparam logic [5:0] PS_LAST_DIV12 = 6'(DIV_SYS12 - 1);
    localparam logic [5:0] PS_LAST_DIV4 = 6'(DIV_SYS4 - 1);
    localparam logic [5:0] PS_LAST_DIV48 = 6'(DIV_SYS48 - 1);
    localparam logic [2:0] PS_LAST_EXT8 = 3'(DIV_EXT8 - 1);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_DIV12 = 2'b00,
        PS_DIV4 = 2'b01,
        PS_DIV48 = 2'b10,
        PS_EXT8 = 2'b11
    } tcsm_prescale_e;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_8RELOAD = 2'b10,
        MODE_IDLE = 2'b11
    } tcsm_mode_e;

    typedef struct packed {
        logic unused7;
        logic tmr2_high_sysclk_sel;
        logic tmr2_low_sysclk_sel;
        logic timer_one_sysclk_sel;
        logic timer_zero_sysclk_sel;
        logic unused2;
        tcsm_prescale_e prescale_code;
    } tcsm_clksel_s;

    typedef struct packed {
        logic gate_en;
        logic counter_sel;
        tcsm_mode_e mode;
    } tcsm_tmode_s;

endpackage : tcsm_pkg

// ===== core/tcsm_sync.sv
// two-flop synchroniser bank for pin inputs
// assumes each lane is a slow level from outside the clk domain
`timescale 1ns/1ps
module tcsm_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // lanes
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] dout_next;

    // ----------------------------------------------------------------
    // per-lane flops; the first stage feeds only the second
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            always_comb begin
                meta_next[g] = din[g];
                dout_next[g] = meta_reg[g];
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    meta_reg[g] <= 1'b0;
                    dout[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= meta_next[g];
                    dout[g] <= dout_next[g];
                end
            end
        end
    endgenerate

endmodule : tcsm_sync

// ===== core/tcsm_timer01.sv
// timer 0/1 clock selection, prescaler and counters with register port
// assumes a byte register port on clk and slow pins sampled by clk
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module tcsm_timer01 (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    output logic [7:0] reg_rd_data,
    // pins
    input wire logic ext_clk_pin,
    input wire logic timer_zero_event_pin,
    input wire logic timer_one_event_pin,
    input wire logic gate_input_zero,
    input wire logic gate_input_one,
    // interrupt requests and timer 2 clock selects
    output logic timer_zero_irq,
    output logic timer_one_irq,
    output logic tmr2_high_sysclk_sel,
    output logic tmr2_low_sysclk_sel
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tcsm_pkg::tcsm_clksel_s clksel_reg, clksel_next;
    tcsm_pkg::tcsm_tmode_s [1:0] mode_reg, mode_next;
    logic [7:0] run_flags_reg, run_flags_next;
    logic [7:0] irq_mask_reg, irq_mask_next;
    logic [7:0] ext_cfg_reg, ext_cfg_next;
    logic [1:0][15:0] count_reg, count_next;
    logic [5:0] div_cnt_reg, div_cnt_next;
    logic [2:0] ext_div_reg, ext_div_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic [1:0] irq_reg, irq_next;
    logic [tcsm_pkg::SYNC_LANES-1:0] pin_prev_reg, pin_prev_next;

    logic [tcsm_pkg::SYNC_LANES-1:0] pin_raw;
    logic [tcsm_pkg::SYNC_LANES-1:0] pin_sync;
    logic ext_rise;
    logic pre_tick;
    logic ck_wr;
    logic [1:0] evt_fall, sys_sel, pol, run, gate_ok, base_tick, count_en, wrap;
    logic [1:0] wr_low, wr_high;
    logic [1:0][15:0] inc_val;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    // pins cross into clk through two flops before any edge logic
    assign pin_raw = {gate_input_one, gate_input_zero, timer_one_event_pin,
                      timer_zero_event_pin, ext_clk_pin};

    tcsm_sync #(.WIDTH(tcsm_pkg::SYNC_LANES)) u_sync (
        .clk(clk),
        .reset(reset),
        .din(pin_raw),
        .dout(pin_sync)
    );

    // edges become one-cycle enables rather than clocks
    assign pin_prev_next = pin_sync;
    assign ext_rise = pin_sync[tcsm_pkg::SYNC_EXTCLK]
                      & ~pin_prev_reg[tcsm_pkg::SYNC_EXTCLK];
    assign ck_wr = reg_wr_stb && (reg_addr == tcsm_pkg::ADDR_CLK_SEL);

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // a write to clock select restarts both dividers so the first
    // period after a code change is a full one
    always_comb begin
        div_cnt_next = div_cnt_reg + 6'h01;
        ext_div_next = ext_div_reg;
        pre_tick = 1'b0;
        unique case (clksel_reg.prescale_code)
            tcsm_pkg::PS_DIV12: pre_tick = (div_cnt_reg == tcsm_pkg::PS_LAST_DIV12);
            tcsm_pkg::PS_DIV4: pre_tick = (div_cnt_reg == tcsm_pkg::PS_LAST_DIV4);
            tcsm_pkg::PS_DIV48: pre_tick = (div_cnt_reg == tcsm_pkg::PS_LAST_DIV48);
            tcsm_pkg::PS_EXT8: begin
                pre_tick = ext_rise && (ext_div_reg == tcsm_pkg::PS_LAST_EXT8);
                ext_div_next = ext_rise ? ext_div_reg + 3'h1 : ext_div_reg;
            end
        endcase
        if (pre_tick) begin
            div_cnt_next = 6'h00;
        end
        if (ck_wr) begin
            div_cnt_next = 6'h00;
            ext_div_next = 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // per-timer enables and increment
    // ----------------------------------------------------------------
    assign sys_sel = {clksel_reg.timer_one_sysclk_sel, clksel_reg.timer_zero_sysclk_sel};
    assign pol = {ext_cfg_reg[tcsm_pkg::EXT_GATE_ONE_POLARITY_BIT], ext_cfg_reg[tcsm_pkg::EXT_GATE_ZERO_POLARITY_BIT]};
    assign run = {run_flags_reg[tcsm_pkg::RF_TR1_BIT], run_flags_reg[tcsm_pkg::RF_TR0_BIT]};

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_timer
            // timer 1 reuses the timer 0 structure with its own bits
            assign evt_fall[t] = pin_prev_reg[tcsm_pkg::SYNC_EVT0 + t]
                                 & ~pin_sync[tcsm_pkg::SYNC_EVT0 + t];
            // sysclk select is ignored in counter mode
            assign base_tick[t] = mode_reg[t].counter_sel ? evt_fall[t]
                                  : (sys_sel[t] | pre_tick);
            assign gate_ok[t] = ~mode_reg[t].gate_en
                                | (pin_sync[tcsm_pkg::SYNC_TIMER_ZERO_GATE_EN + t] == pol[t]);
            assign count_en[t] = run[t] & gate_ok[t] & base_tick[t];
            assign wr_low[t] = reg_wr_stb
                               && (reg_addr == (t == 0 ? tcsm_pkg::ADDR_T0_LOW
                                                       : tcsm_pkg::ADDR_T1_LOW));
            assign wr_high[t] = reg_wr_stb
                                && (reg_addr == (t == 0 ? tcsm_pkg::ADDR_T0_HIGH
                                                        : tcsm_pkg::ADDR_T1_HIGH));

            // mode decides width and wrap point of the count
            always_comb begin
                logic [12:0] c13;
                c13 = 13'({count_reg[t][15:8], count_reg[t][4:0]} + 13'h0001);
                inc_val[t] = count_reg[t];
                wrap[t] = 1'b0;
                unique case (mode_reg[t].mode)
                    tcsm_pkg::MODE_13BIT: begin
                        // low byte bits 7..5 are left as they were
                        inc_val[t] = {c13[12:5], count_reg[t][7:5], c13[4:0]};
                        wrap[t] = count_en[t]
                                  & (&{count_reg[t][15:8], count_reg[t][4:0]});
                    end
                    tcsm_pkg::MODE_16BIT: begin
                        inc_val[t] = count_reg[t] + 16'h0001;
                        wrap[t] = count_en[t] & (&count_reg[t]);
                    end
                    tcsm_pkg::MODE_8RELOAD: begin
                        wrap[t] = count_en[t] & (&count_reg[t][7:0]);
                        inc_val[t][7:0] = (&count_reg[t][7:0]) ? count_reg[t][15:8]
                                          : count_reg[t][7:0] + 8'h01;
                    end
                    tcsm_pkg::MODE_IDLE: begin
                        inc_val[t] = count_reg[t];
                    end
                endcase
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // register file next state
    // ----------------------------------------------------------------
    // a byte write wins over an increment in the same cycle; an
    // overflow in the cycle that software clears a flag still sets it
    always_comb begin
        clksel_next = clksel_reg;
        mode_next = mode_reg;
        run_flags_next = run_flags_reg;
        irq_mask_next = irq_mask_reg;
        ext_cfg_next = ext_cfg_reg;
        count_next = count_reg;
        if (ck_wr) begin
            clksel_next = reg_wr_data & tcsm_pkg::CLK_SEL_WMASK;
        end
        if (reg_wr_stb && reg_addr == tcsm_pkg::ADDR_MODE) begin
            mode_next = reg_wr_data;
        end
        // run bit only gates counting; the count is untouched
        if (reg_wr_stb && reg_addr == tcsm_pkg::ADDR_RUN_FLAGS) begin
            run_flags_next = reg_wr_data;
        end
        if (reg_wr_stb && reg_addr == tcsm_pkg::ADDR_IRQ_MASK) begin
            irq_mask_next = reg_wr_data;
        end
        if (reg_wr_stb && reg_addr == tcsm_pkg::ADDR_EXT_CFG) begin
            ext_cfg_next = reg_wr_data;
        end
        if (wrap[0]) begin
            run_flags_next[tcsm_pkg::RF_TF0_BIT] = 1'b1;
        end
        if (wrap[1]) begin
            run_flags_next[tcsm_pkg::RF_TF1_BIT] = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (count_en[i]) begin
                count_next[i] = inc_val[i];
            end
            if (wr_low[i]) begin
                count_next[i][7:0] = reg_wr_data;
            end
            if (wr_high[i]) begin
                count_next[i][15:8] = reg_wr_data;
            end
        end
        // requests follow the flags, each through its own enable
        irq_next[0] = run_flags_reg[tcsm_pkg::RF_TF0_BIT]
                      & irq_mask_reg[tcsm_pkg::IRQ_ET0_BIT];
        irq_next[1] = run_flags_reg[tcsm_pkg::RF_TF1_BIT]
                      & irq_mask_reg[tcsm_pkg::IRQ_ET1_BIT];
    end

    // read data stand only in the cycle after the strobe
    always_comb begin
        rd_data_next = 8'h00;
        if (reg_rd_stb) begin
            unique case (reg_addr)
                tcsm_pkg::ADDR_CLK_SEL: rd_data_next = clksel_reg;
                tcsm_pkg::ADDR_MODE: rd_data_next = mode_reg;
                tcsm_pkg::ADDR_RUN_FLAGS: rd_data_next = run_flags_reg;
                tcsm_pkg::ADDR_IRQ_MASK: rd_data_next = irq_mask_reg;
                tcsm_pkg::ADDR_EXT_CFG: rd_data_next = ext_cfg_reg;
                // upper low-byte bits are returned raw in mode 0
                tcsm_pkg::ADDR_T0_LOW: rd_data_next = count_reg[0][7:0];
                tcsm_pkg::ADDR_T1_LOW: rd_data_next = count_reg[1][7:0];
                tcsm_pkg::ADDR_T0_HIGH: rd_data_next = count_reg[0][15:8];
                tcsm_pkg::ADDR_T1_HIGH: rd_data_next = count_reg[1][15:8];
                default: rd_data_next = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            clksel_reg <= tcsm_pkg::CLK_SEL_RESET;
            mode_reg <= tcsm_pkg::REG_RESET;
            run_flags_reg <= tcsm_pkg::REG_RESET;
            irq_mask_reg <= tcsm_pkg::REG_RESET;
            ext_cfg_reg <= tcsm_pkg::REG_RESET;
            count_reg <= '0;
            div_cnt_reg <= 6'h00;
            ext_div_reg <= 3'h0;
            rd_data_reg <= 8'h00;
            irq_reg <= 2'b00;
            pin_prev_reg <= '0;
        end else begin
            clksel_reg <= clksel_next;
            mode_reg <= mode_next;
            run_flags_reg <= run_flags_next;
            irq_mask_reg <= irq_mask_next;
            ext_cfg_reg <= ext_cfg_next;
            count_reg <= count_next;
            div_cnt_reg <= div_cnt_next;
            ext_div_reg <= ext_div_next;
            rd_data_reg <= rd_data_next;
            irq_reg <= irq_next;
            pin_prev_reg <= pin_prev_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign timer_zero_irq = irq_reg[0];
    assign timer_one_irq = irq_reg[1];
    assign tmr2_high_sysclk_sel = clksel_reg.tmr2_high_sysclk_sel;
    assign tmr2_low_sysclk_sel = clksel_reg.tmr2_low_sysclk_sel;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // gap since last prescaler tick, invalidated by a code write
    logic [5:0] gap_reg;
    logic gap_valid_reg;
    always_ff @(posedge clk) begin
        if (reset || ck_wr) begin
            gap_reg <= 6'h00;
            gap_valid_reg <= 1'b0;
        end else if (pre_tick) begin
            gap_reg <= 6'h00;
            gap_valid_reg <= 1'b1;
        end else if (gap_reg != 6'h3F) begin
            gap_reg <= gap_reg + 6'h01;
        end
    end

    sequence s_t0_wrap13;
        count_en[0] && mode_reg[0].mode == tcsm_pkg::MODE_13BIT
        && (&{count_reg[0][15:8], count_reg[0][4:0]}) && !wr_low[0] && !wr_high[0];
    endsequence

    sequence s_t0_edge16;
        mode_reg[0].counter_sel && mode_reg[0].mode == tcsm_pkg::MODE_16BIT
        && run[0] && gate_ok[0] && evt_fall[0] && !wr_low[0] && !wr_high[0];
    endsequence

    a_clksel_reserved: assert property (ck_wr |=> !clksel_reg[7] && !clksel_reg[2])
        else $error("reserved clock select bits not zero");
    a_clksel_readback: assert property (
        reg_rd_stb && reg_addr == tcsm_pkg::ADDR_CLK_SEL
        |=> reg_rd_data[7] == 1'b0 && reg_rd_data[2] == 1'b0)
        else $error("reserved bits read back nonzero");
    a_tmr2_select: assert property (
        ck_wr |=> tmr2_high_sysclk_sel == $past(reg_wr_data[6])
        && tmr2_low_sysclk_sel == $past(reg_wr_data[5]))
        else $error("timer 2 clock select not taken");
    a_prescale_gap: assert property (
        pre_tick && gap_valid_reg && !ck_wr
        && clksel_reg.prescale_code == tcsm_pkg::PS_DIV12
        |-> gap_reg == tcsm_pkg::PS_LAST_DIV12)
        else $error("divide by 12 period wrong");
    a_prescale_gap48: assert property (
        pre_tick && gap_valid_reg && !ck_wr
        && clksel_reg.prescale_code == tcsm_pkg::PS_DIV48
        |-> gap_reg == tcsm_pkg::PS_LAST_DIV48)
        else $error("divide by 48 period wrong");
    a_wrap_flag: assert property (
        s_t0_wrap13 |=> run_flags_reg[tcsm_pkg::RF_TF0_BIT]
        && count_reg[0][15:8] == 8'h00 && count_reg[0][4:0] == 5'h00)
        else $error("13-bit wrap did not clear count and set flag");
    a_irq_follow: assert property (
        s_t0_wrap13 ##1 irq_mask_reg[tcsm_pkg::IRQ_ET0_BIT] |=> timer_zero_irq)
        else $error("enabled overflow did not raise request");
    a_irq_masked: assert property (
        !irq_mask_reg[tcsm_pkg::IRQ_ET1_BIT] |=> !timer_one_irq)
        else $error("masked timer 1 raised request");
    a_event_count: assert property (
        s_t0_edge16 |=> count_reg[0] == 16'($past(count_reg[0]) + 16'h0001))
        else $error("falling event edge not counted");
    a_run_gate: assert property (
        !run[1] && !wr_low[1] && !wr_high[1] |=> $stable(count_reg[1]))
        else $error("stopped timer changed count");
    a_gate_block: assert property (
        mode_reg[0].gate_en && pin_sync[tcsm_pkg::SYNC_TIMER_ZERO_GATE_EN]
        != ext_cfg_reg[tcsm_pkg::EXT_GATE_ZERO_POLARITY_BIT] && !wr_low[0] && !wr_high[0]
        |=> $stable(count_reg[0]))
        else $error("inactive gate let timer 0 count");
    a_sysclk_count: assert property (
        run[0] && !mode_reg[0].gate_en && !mode_reg[0].counter_sel
        && clksel_reg.timer_zero_sysclk_sel && mode_reg[0].mode == tcsm_pkg::MODE_16BIT
        && !wr_low[0] && !wr_high[0]
        |=> count_reg[0] == 16'($past(count_reg[0]) + 16'h0001))
        else $error("system clock timebase not counting");

endmodule : tcsm_timer01

// ===== sim/tcsm_pin_model.sv
// pin-side model: event pins, gate levels and external clock pin
// assumes the bench calls its tasks; levels change just after clk rises
`timescale 1ns/1ps
module tcsm_pin_model (
    // clock
    input wire logic clk,
    // pins towards the block
    output logic ext_clk_pin,
    output logic evt0,
    output logic evt1,
    output logic timer_zero_gate_en,
    output logic gate1
);
    // idle levels; external clock held still since no scenario uses it
    initial begin
        ext_clk_pin = 1'b0;
        evt0 = 1'b1;
        evt1 = 1'b1;
        timer_zero_gate_en = 1'b1;
        gate1 = 1'b1;
    end

    // one falling edge; each level held three cycles so it is sampled
    task automatic pulse(input logic which);
        @(posedge clk);
        if (which) evt1 <= 1'b0; else evt0 <= 1'b0;
        repeat (3) @(posedge clk);
        if (which) evt1 <= 1'b1; else evt0 <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : pulse
endmodule : tcsm_pin_model

// ===== sim/test_timer01_clock_select_mode0.sv
// self-checking bench for the timer 0/1 block over its byte register port
// assumes the pin model drives all pins; clk at 250 MHz
`timescale 1ns/1ps
module test_timer01_clock_select_mode0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_stb = 1'b0;
    logic reg_rd_stb = 1'b0;
    logic [7:0] reg_rd_data;
    logic ext_clk, ev0, ev1, g0, g1, irq0, irq1, t2h, t2l;
    logic [7:0] d, hi;
    int bad_count = 0;
    int comparisons = 0;
    int n;
    logic [7:0] cks [4] = '{8'h00, 8'h01, 8'h02, 8'h08};
    int divs [4] = '{12, 4, 48, 1};

    always #2 clk = ~clk;

    tcsm_timer01 u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
        .reg_rd_data(reg_rd_data), .ext_clk_pin(ext_clk), .timer_zero_event_pin(ev0),
        .timer_one_event_pin(ev1), .gate_input_zero(g0), .gate_input_one(g1),
        .timer_zero_irq(irq0), .timer_one_irq(irq1), .tmr2_high_sysclk_sel(t2h),
        .tmr2_low_sysclk_sel(t2l));
    tcsm_pin_model u_pins (.clk(clk), .ext_clk_pin(ext_clk), .evt0(ev0), .evt1(ev1),
        .timer_zero_gate_en(g0), .gate1(g1));

    // -------------------- bus and check tasks --------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= v;
        reg_wr_stb <= 1'b1;
        @(posedge clk);
        reg_wr_stb <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_stb <= 1'b1;
        @(posedge clk);
        reg_rd_stb <= 1'b0;
        #1 v = reg_rd_data;
    endtask : rd
    task automatic print_verdict;
        $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // watchdog so a hang still reaches the verdict
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    // -------------------- scenarios --------------------
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h8E, d); chk(d, 8'h00);
        wr(8'h8E, 8'hFF); rd(8'h8E, d); chk(d, 8'h7B);
        chk({6'h00, t2h, t2l}, 8'h03);
        rd(8'h90, d); chk(d, 8'h00);
        // timer 0 counts event edges across the 13-bit wrap
        wr(8'h8E, 8'h00); wr(8'h89, 8'h04); wr(8'h8A, 8'h1E); wr(8'h8C, 8'hFF);
        wr(8'h88, 8'h10); rd(8'h8A, d); chk(d & 8'h1F, 8'h1E);
        u_pins.pulse(1'b0); rd(8'h8A, d); chk(d & 8'h1F, 8'h1F);
        u_pins.pulse(1'b0); rd(8'h8A, d); chk(d & 8'h1F, 8'h00);
        rd(8'h8C, d); chk(d, 8'h00);
        rd(8'h88, d); chk(d, 8'h30);
        chk({7'h00, irq0}, 8'h00);
        wr(8'hA8, 8'h02); repeat (2) @(posedge clk); chk({7'h00, irq0}, 8'h01);
        // gate input held high: inactive at polarity 0, active at 1
        wr(8'h88, 8'h00); wr(8'h89, 8'h0C); wr(8'hE4, 8'h00); wr(8'h88, 8'h10);
        u_pins.pulse(1'b0); rd(8'h8A, d); chk(d & 8'h1F, 8'h00);
        wr(8'hE4, 8'h08); u_pins.pulse(1'b0); rd(8'h8A, d); chk(d & 8'h1F, 8'h01);
        // 16-bit mode carries out of the low byte; mode bits are per timer
        wr(8'h88, 8'h00); wr(8'h89, 8'h05); wr(8'h8A, 8'hFF); wr(8'h8C, 8'h00);
        wr(8'h88, 8'h10); u_pins.pulse(1'b0); rd(8'h8C, d); chk(d, 8'h01);
        // timer 1 mirrors timer 0 on its own bytes and flags
        wr(8'h88, 8'h00); wr(8'h89, 8'h40); wr(8'h8B, 8'h1F); wr(8'h8D, 8'hFF);
        wr(8'h88, 8'h40); u_pins.pulse(1'b1); rd(8'h8B, d); chk(d & 8'h1F, 8'h00);
        rd(8'h88, d); chk(d, 8'hC0);
        wr(8'hA8, 8'h08); repeat (2) @(posedge clk); chk({7'h00, irq1}, 8'h01);
        // timebase rates in 16-bit mode; three counts of slack either way for phase
        wr(8'h88, 8'h00); wr(8'h89, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(8'h8E, cks[i]); wr(8'h8A, 8'h00); wr(8'h8C, 8'h00); wr(8'h88, 8'h10);
            repeat (478) @(posedge clk);
            wr(8'h88, 8'h00); rd(8'h8A, d); rd(8'h8C, hi);
            n = {hi, d};
            chk(8'(n >= 480 / divs[i] - 3 && n <= 480 / divs[i] + 3), 8'h01);
        end
        print_verdict();
    end
endmodule : test_timer01_clock_select_mode0
